// ==== hw/sag_top.sv ====
`timescale 1ns/1ps
`include "sag_params.svh"

module sag_top #(
  parameter logic [15:0] PROT_BYTES = `SAG_PROT_BYTES,
  parameter logic [3:0]  GR_ROW     = `SAG_GR_ROW
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire sag_pkg::sag_cmd_t cmd,
  input  wire logic [1:0]        cap_pin,
  input  wire logic [9:0]        ms_rdata,
  output sag_pkg::sag_ms_t       ms_req,
  output sag_pkg::sag_err_t      err,
  output logic [15:0]            eff_addr,
  output logic [15:0]            byte_cnt,
  output logic [4:0]             bus_val,
  output logic [39:0]            dr_view
);
  import sag_pkg::*;

  // Protected area must leave room inside the smallest storage.
  if (PROT_BYTES > `SAG_MAX_4K) begin : g_chk
    $error("PROT_BYTES exceeds the smallest storage size");
  end

  // Eight data registers of parity plus four data bits.
  logic [7:0][4:0] dr_r;
  logic [1:0]      ext_r;
  logic [9:0]      aux_r [16][16];
  sag_ms_t         ms_r;
  sag_err_t        err_r;
  logic [15:0]     ea_r;
  logic [15:0]     cnt_r;
  logic [4:0]      bus_r;
  logic            blk_r;
  logic            fpend_r;
  logic [1:0]      cap_s1_r;
  logic [1:0]      cap_s2_r;
  logic [1:0]      cap_s3_r;
  sag_cap_t        cap_r;

  logic [4:0]      src_val;
  logic [4:0]      mod_val;
  logic [15:0]     gr_val;
  logic [15:0]     ea_nxt;
  sag_err_t        chk;
  logic            do_chk;
  logic [3:0]      aux_row;
  logic [9:0]      aux_rd;
  logic            cmd_ok;

  // Odd parity over a nibble, so an all-zero register still carries a one.
  function automatic logic par4(input logic [3:0] d);
    par4 = ~^d;
  endfunction

  // Modifier: value plus one, minus one or unchanged, parity rebuilt.
  function automatic logic [4:0] modify(input logic [4:0] v,
                                        input sag_op_t op);
    logic [3:0] d;
    d = v[3:0];
    if (op == OP_INC) begin
      d = d + 4'h1;
    end else if (op == OP_DEC) begin
      d = d - 4'h1;
    end
    modify = {par4(d), d};
  endfunction

  // Largest legal address for the installed capacity.
  function automatic logic [15:0] cap_max(input sag_cap_t c);
    unique case (c)
      CAP_4K:  cap_max = `SAG_MAX_4K;
      CAP_8K:  cap_max = `SAG_MAX_8K;
      CAP_16K: cap_max = `SAG_MAX_16K;
      default: cap_max = `SAG_MAX_4K;
    endcase
  endfunction

  // Both address checks, used for every generated address.
  function automatic sag_err_t addr_chk(input logic [15:0] a,
                                        input sag_cap_t c);
    sag_err_t e;
    e.prot = (a < PROT_BYTES);
    e.cap  = (a > cap_max(c));
    addr_chk = e;
  endfunction

  // Operand decode: direct or indexed effective address.
  function automatic logic [15:0] gen_addr(input logic [15:0] opnd,
                                           input logic [15:0] gr);
    logic [3:0]  bsel;
    logic [15:0] disp;
    bsel = opnd[`SAG_BSEL_MSB:`SAG_BSEL_LSB];
    disp = {4'h0, opnd[`SAG_DISP_MSB:0]};
    if (!bsel[3]) begin
      gen_addr = {1'b0, opnd[14:0]};
    end else begin
      gen_addr = gr + disp;
    end
  endfunction

  // Capacity strap: a change counts once stages two and three agree.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_s1_r <= 2'h0;
      cap_s2_r <= 2'h0;
      cap_s3_r <= 2'h0;
    end else begin
      cap_s1_r <= cap_pin;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  // The unused strap code falls back to the smallest storage.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_r <= CAP_4K;
    end else if (cap_s2_r == cap_s3_r) begin
      cap_r <= sag_cap_t'(cap_s3_r);
    end
  end

  // Source selection, modifier and aux read port.
  always_comb begin
    cmd_ok  = cmd.valid;
    src_val = dr_r[cmd.src];
    mod_val = modify(src_val, cmd.op);
    aux_row = dr_r[DR_P][3:0];
    // Both row zero steps force the row, the store as well as the fetch.
    if (cmd.op == OP_FETCH_AUX0 || cmd.op == OP_STORE_AUX0) begin
      aux_row = 4'h0;
    end
    aux_rd  = aux_r[aux_row][cmd.col];
  end

  // General register n sits in two bytes of the register row.
  always_comb begin
    logic [2:0] n;
    n      = cmd.opnd1[14:12];
    gr_val = {aux_r[GR_ROW][{n, 1'b0}][8:5],
              aux_r[GR_ROW][{n, 1'b0}][3:0],
              aux_r[GR_ROW][{n, 1'b1}][8:5],
              aux_r[GR_ROW][{n, 1'b1}][3:0]};
  end

  // Address generation and checking for the three address steps.
  always_comb begin
    ea_nxt = ea_r;
    do_chk = 1'b0;
    if (cmd_ok) begin
      unique case (cmd.op)
        OP_GEN, OP_GEN_IO: begin
          ea_nxt = gen_addr(cmd.opnd1, gr_val);
          do_chk = 1'b1;
        end
        OP_LOW: begin
          ea_nxt = ea_r + {8'h00, cmd.len};
          do_chk = 1'b1;
        end
        default: begin
          ea_nxt = ea_r;
        end
      endcase
    end
    chk = addr_chk(ea_nxt, cap_r);
  end

  // Effective address, I/O byte count and error strobes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ea_r  <= 16'h0000;
      cnt_r <= 16'h0000;
      err_r <= '0;
      blk_r <= 1'b0;
    end else begin
      ea_r  <= ea_nxt;
      err_r <= do_chk ? chk : '0;
      if (do_chk) begin
        blk_r <= chk.prot | chk.cap;
      end
      if (cmd_ok && cmd.op == OP_GEN_IO) begin
        cnt_r <= cmd.opnd2;
      end
    end
  end

  // Extension latches for the 4096 and 8192 positions.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_r <= 2'h0;
    end else if (cmd_ok && cmd.op == OP_SET_EXT) begin
      ext_r <= cmd.imm[1:0];
    end
  end

  // Main storage requests; a blocked address never reaches the array.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ms_r    <= '0;
      fpend_r <= 1'b0;
    end else begin
      ms_r.rd <= cmd_ok && cmd.op == OP_FETCH_MS && !blk_r;
      ms_r.wr <= cmd_ok && cmd.op == OP_STORE_MS && !blk_r;
      fpend_r <= cmd_ok && cmd.op == OP_FETCH_MS && !blk_r;
      if (cmd_ok && (cmd.op == OP_FETCH_MS ||
                     cmd.op == OP_STORE_MS)) begin
        ms_r.addr  <= {ext_r, dr_r[DR_S][3:0],
                       dr_r[DR_T][3:0], dr_r[DR_R][3:0]};
        ms_r.wdata <= {dr_r[DR_U], dr_r[DR_L]};
      end
    end
  end

  // Auxiliary storage in flops; only the store steps write it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int r = 0; r < 16; r++) begin
        for (int c = 0; c < 16; c++) begin
          aux_r[r][c] <= `SAG_BYTE_RST;
        end
      end
    end else if (cmd_ok && (cmd.op == OP_STORE_AUX ||
                            cmd.op == OP_STORE_AUX0)) begin
      aux_r[aux_row][cmd.col] <= {dr_r[DR_U], dr_r[DR_L]};
    end
  end

  // Data registers: one transfer per step; returning fetch data wins
  // because its assignment comes after the step's in the same block.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        dr_r[i] <= `SAG_DR_RST;
      end
    end else begin
      if (cmd_ok) begin
        unique case (cmd.op)
          OP_LOAD: begin
            dr_r[cmd.dst] <= cmd.imm;
          end
          OP_MOVE, OP_INC, OP_DEC: begin
            dr_r[cmd.dst] <= mod_val;
          end
          OP_FETCH_AUX, OP_FETCH_AUX0: begin
            dr_r[DR_U] <= aux_rd[9:5];
            dr_r[DR_L] <= aux_rd[4:0];
          end
          default: begin
            dr_r[DR_E] <= dr_r[DR_E];
          end
        endcase
      end
      if (fpend_r) begin
        dr_r[DR_U] <= ms_rdata[9:5];
        dr_r[DR_L] <= ms_rdata[4:0];
      end
    end
  end

  // Last value placed on the common bus by a register step.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_r <= `SAG_DR_RST;
    end else if (cmd_ok && (cmd.op == OP_MOVE || cmd.op == OP_INC ||
                            cmd.op == OP_DEC)) begin
      bus_r <= mod_val;
    end else if (cmd_ok && cmd.op == OP_LOAD) begin
      bus_r <= cmd.imm;
    end
  end

  // Every output is a flop or a flop array.
  assign ms_req   = ms_r;
  assign err      = err_r;
  assign eff_addr = ea_r;
  assign byte_cnt = cnt_r;
  assign bus_val  = bus_r;
  assign dr_view  = dr_r;

endmodule

// ==== hw/sag_params.svh ====
`ifndef SAG_PARAMS_SVH
`define SAG_PARAMS_SVH
`define SAG_DISP_MSB   11
`define SAG_BSEL_LSB   12
`define SAG_BSEL_MSB   15
`define SAG_PROT_BYTES 16'h0090
`define SAG_MAX_4K     16'h0FFF
`define SAG_MAX_8K     16'h1FFF
`define SAG_MAX_16K    16'h3FFF
`define SAG_GR_ROW     4'h1
`define SAG_DR_RST     5'h10
`define SAG_BYTE_RST   10'h210
`endif

// ==== hw/sag_pkg.sv ====
package sag_pkg;

  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD, OP_MOVE, OP_INC, OP_DEC,
    OP_FETCH_MS, OP_STORE_MS, OP_FETCH_AUX, OP_STORE_AUX,
    OP_FETCH_AUX0, OP_STORE_AUX0, OP_SET_EXT,
    OP_GEN, OP_GEN_IO, OP_LOW
  } sag_op_t;

  typedef enum logic [2:0] {
    DR_S, DR_T, DR_R, DR_U, DR_L, DR_P, DR_I, DR_E
  } sag_dr_t;

  typedef enum logic [1:0] {CAP_4K, CAP_8K, CAP_16K} sag_cap_t;

  typedef struct packed {
    logic        valid;
    sag_op_t     op;
    sag_dr_t     dst;
    sag_dr_t     src;
    logic [4:0]  imm;
    logic [3:0]  col;
    logic [15:0] opnd1;
    logic [15:0] opnd2;
    logic [7:0]  len;
  } sag_cmd_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [13:0] addr;
    logic [9:0]  wdata;
  } sag_ms_t;

  typedef struct packed {
    logic prot;
    logic cap;
  } sag_err_t;

endpackage

// ==== test/sag_monitor.sv ====
`timescale 1ns/1ps
module sag_monitor #(
  parameter logic [15:0] PROT_BYTES = 16'h0090
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire sag_pkg::sag_cmd_t cmd,
  input wire logic [9:0]        ms_rdata,
  input wire sag_pkg::sag_ms_t  ms_req,
  input wire sag_pkg::sag_err_t err,
  input wire logic [15:0]       eff_addr,
  input wire logic [15:0]       byte_cnt,
  input wire logic [39:0]       dr_view
);
  import sag_pkg::*;
  logic       chk_op;
  logic       rd_op;
  logic [9:0] ul;
  logic [11:0] snib;
  // Only the address forming steps may raise an address error.
  assign chk_op = cmd.valid && cmd.op inside {OP_GEN, OP_GEN_IO, OP_LOW};
  assign rd_op  = cmd.valid && cmd.op == OP_FETCH_MS;
  assign ul     = {dr_view[19:15], dr_view[24:20]};
  assign snib   = {dr_view[3:0], dr_view[8:5], dr_view[13:10]};
  // One clock domain, so clock and reset are named once.
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_direct_addr:
    assert property (cmd.valid && cmd.op == OP_GEN && !cmd.opnd1[15]
      |=> eff_addr == {1'b0, $past(cmd.opnd1[14:0])}) else $error("direct");
  a_prot_flag:
    assert property (chk_op |=> err.prot == (eff_addr < PROT_BYTES))
    else $error("protect flag");
  a_err_cause:
    assert property (err.prot || err.cap |-> $past(chk_op))
    else $error("stray error");
  a_io_count:
    assert property (cmd.valid && cmd.op == OP_GEN_IO
      |=> byte_cnt == $past(cmd.opnd2)) else $error("byte count");
  a_low_addr:
    assert property (cmd.valid && cmd.op == OP_LOW
      |=> eff_addr == $past(eff_addr) + {8'h00, $past(cmd.len)})
    else $error("low address");
  a_rd_cause:
    assert property (ms_req.rd |-> $past(rd_op)) else $error("stray read");
  a_fetch_load:
    assert property (ms_req.rd |=> ul == $past(ms_rdata))
    else $error("fetch load");
  a_store_data:
    assert property (ms_req.wr |-> ms_req.wdata == ul)
    else $error("store data");
  a_addr_nibbles:
    assert property (ms_req.rd || ms_req.wr |-> ms_req.addr[11:0] == snib)
    else $error("address nibbles");
  a_no_access:
    assert property (rd_op && (err.prot || err.cap) |=> !ms_req.rd)
    else $error("access not suppressed");
endmodule

bind sag_top sag_monitor #(.PROT_BYTES(PROT_BYTES)) i_mon (.clk(clk),
  .sys_rst(sys_rst), .cmd(cmd), .ms_rdata(ms_rdata), .ms_req(ms_req),
  .err(err), .eff_addr(eff_addr), .byte_cnt(byte_cnt), .dr_view(dr_view));

// ==== test/sag_ms_model.sv ====
`timescale 1ns/1ps
module sag_ms_model (
  input  wire logic             clk,
  input  wire sag_pkg::sag_ms_t ms_req,
  output logic [9:0]            ms_rdata
);
  import sag_pkg::*;
  logic [9:0] mem [16384];
  logic [9:0] last_r = 10'h000;
  // Store strobe writes a whole byte; the last read byte is remembered.
  always @(posedge clk) begin
    if (ms_req.wr) mem[ms_req.addr] <= ms_req.wdata;
    if (ms_req.rd) last_r <= mem[ms_req.addr];
  end
  // Off the read cycle the lines show the inverse, so stale data is caught.
  assign ms_rdata = ms_req.rd ? mem[ms_req.addr] : ~last_r;
endmodule

// ==== test/sag_top_test.sv ====
`timescale 1ns/1ps
module sag_top_test;
  import sag_pkg::*;
  logic        clk;
  logic        sys_rst;
  sag_cmd_t    cmd;
  logic [1:0]  cap_pin;
  logic [9:0]  ms_rdata;
  sag_ms_t     ms_req;
  sag_err_t    err;
  logic [15:0] eff_addr;
  logic [15:0] byte_cnt;
  logic [4:0]  bus_val;
  logic [39:0] dr_view;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  sag_top i_dut (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .cap_pin(cap_pin),
    .ms_rdata(ms_rdata), .ms_req(ms_req), .err(err), .eff_addr(eff_addr),
    .byte_cnt(byte_cnt), .bus_val(bus_val), .dr_view(dr_view));
  sag_ms_model i_mem (.clk(clk), .ms_req(ms_req), .ms_rdata(ms_rdata));

  // Free running clock; the hang guard ends the run if a step stalls.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string what, logic [39:0] seen, logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // One micro step per call; calls in a row are back to back.
  task automatic go(sag_op_t o, sag_dr_t d, sag_dr_t s, logic [4:0] im,
                    logic [15:0] a);
    sag_cmd_t c;
    c = '0;
    c.valid = 1'b1;
    c.op = o;
    c.dst = d;
    c.src = s;
    c.imm = im;
    c.col = im[3:0];
    c.opnd1 = a;
    c.opnd2 = {a[7:0], a[15:8]};
    c.len = a[7:0];
    // The whole step changes in one assignment, so valid never glitches.
    @(negedge clk);
    cmd = c;
  endtask

  task automatic idle(int n);
    repeat (n) begin
      @(negedge clk);
      cmd.valid = 1'b0;
    end
  endtask

  task automatic ld(sag_dr_t d, logic [4:0] im);
    go(OP_LOAD, d, d, im, 16'h0000);
  endtask

  task automatic gen_chk(logic [15:0] a, logic [15:0] ea, logic [1:0] e);
    go(OP_GEN, DR_S, DR_S, 5'h00, a);
    idle(1);
    chk("eff_addr", 40'(eff_addr), 40'(ea));
    chk("err", 40'(err), 40'(e));
  endtask

  task automatic put_aux(logic [4:0] col, logic [4:0] u, logic [4:0] l);
    ld(DR_U, u);
    ld(DR_L, l);
    go(OP_STORE_AUX, DR_S, DR_S, col, 16'h0000);
  endtask

  // Each capacity: last legal byte passes, the next one is refused.
  task automatic t_caps();
    logic [15:0] lim;
    for (int c = 0; c < 3; c++) begin
      cap_pin = c[1:0];
      idle(4);
      lim = (16'h1000 << c) - 16'h0001;
      gen_chk(lim, lim, 2'b00);
      gen_chk(lim + 16'h0001, lim + 16'h0001, 2'b01);
    end
    gen_chk(16'h7FFF, 16'h7FFF, 2'b01);
    gen_chk(16'h008F, 16'h008F, 2'b10);
    gen_chk(16'h0090, 16'h0090, 2'b00);
  endtask

  // Registers 1 and 7 as bases; the first sum wraps into the low area.
  task automatic t_index();
    ld(DR_P, 5'h01);
    put_aux(5'h02, 5'h0F, 5'h0F);
    put_aux(5'h03, 5'h0F, 5'h00);
    put_aux(5'h0E, 5'h01, 5'h02);
    put_aux(5'h0F, 5'h03, 5'h04);
    gen_chk(16'h9020, 16'h0010, 2'b10);
    gen_chk(16'h9ABC, 16'h0AAC, 2'b00);
    gen_chk(16'hF001, 16'h1235, 2'b00);
    go(OP_FETCH_AUX, DR_S, DR_S, 5'h03, 16'h0000);
    idle(1);
    chk("aux", dr_view[24:15], {5'h00, 5'h0F});
    // Row zero steps must leave the row register's row untouched.
    ld(DR_U, 5'h07);
    ld(DR_L, 5'h18);
    go(OP_STORE_AUX0, DR_S, DR_S, 5'h05, 16'h0000);
    go(OP_FETCH_AUX, DR_S, DR_S, 5'h05, 16'h0000);
    idle(1);
    chk("aux row", dr_view[24:15], {5'h10, 5'h10});
    go(OP_FETCH_AUX0, DR_S, DR_S, 5'h05, 16'h0000);
    idle(1);
    chk("aux row 0", dr_view[24:15], {5'h18, 5'h07});
  endtask

  task automatic t_io();
    go(OP_GEN_IO, DR_S, DR_S, 5'h00, 16'h0200);
    idle(1);
    chk("eff_addr", 40'(eff_addr), 40'h200);
    chk("byte_cnt", 40'(byte_cnt), 40'h2);
    go(OP_LOW, DR_S, DR_S, 5'h00, 16'h00FF);
    idle(1);
    chk("low", 40'(eff_addr), 40'h2FF);
  endtask

  // Store then fetch back at 0x2123; a fetch after a failed check is void.
  task automatic t_mem();
    ld(DR_S, 5'h01);
    ld(DR_T, 5'h02);
    ld(DR_R, 5'h03);
    go(OP_SET_EXT, DR_S, DR_S, 5'h02, 16'h0000);
    put_aux(5'h00, 5'h15, 5'h0A);
    go(OP_STORE_MS, DR_S, DR_S, 5'h00, 16'h0000);
    idle(1);
    chk("wr", 40'(ms_req.wr), 40'h1);
    ld(DR_U, 5'h00);
    ld(DR_L, 5'h00);
    go(OP_FETCH_MS, DR_S, DR_S, 5'h00, 16'h0000);
    idle(1);
    chk("ms_addr", 40'(ms_req.addr), 40'h2123);
    idle(1);
    chk("fetch", dr_view[24:15], {5'h0A, 5'h15});
    ld(DR_U, 5'h00);
    ld(DR_L, 5'h00);
    go(OP_GEN, DR_S, DR_S, 5'h00, 16'h0010);
    go(OP_FETCH_MS, DR_S, DR_S, 5'h00, 16'h0000);
    idle(1);
    chk("rd", 40'(ms_req.rd), 40'h0);
    idle(1);
    chk("void fetch", dr_view[24:15], 40'h0);
  endtask

  // Modifier wraps the four data bits and regenerates odd parity.
  task automatic t_modify();
    ld(DR_I, 5'h0F);
    go(OP_INC, DR_E, DR_I, 5'h00, 16'h0000);
    go(OP_DEC, DR_T, DR_E, 5'h00, 16'h0000);
    go(OP_MOVE, DR_R, DR_I, 5'h00, 16'h0000);
    idle(1);
    chk("inc", dr_view[39:35], 40'h10);
    chk("dec", dr_view[9:5], 40'h1F);
    chk("move", dr_view[14:10], 40'h1F);
    chk("bus_val", 40'(bus_val), 40'h1F);
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cmd = '0;
    cap_pin = 2'd0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk("dr_view", dr_view, {8{5'h10}});
    chk("bus_val", 40'(bus_val), 40'h10);
    t_caps();
    t_index();
    t_io();
    t_mem();
    t_modify();
    tally_and_finish();
  end
endmodule
